// ===== wsss_pkg.sv
// wake sequence supply states: register map, field layout, reset values, state codes
// assumes a 40 MHz system clock and an AXI4-Lite register bus with 32-bit data
// Behaviour
// - phase one applies its setting, minimum dwell
// - after dwell, advance only when supplies good
// - phase two applies setting, own dwell
// - dwell field N gives 2**N cycles
// - clock-gate bit stops tile clock in state
// - analogue regulator mode: 0 pwm, 1 pfm
// - core regulator mode: 0 pwm, 1 pfm
// - io supply enabled per state bit
// - pll linear regulator enabled per state bit
// - analogue enable bit read-only, device fixed
// - core regulator enabled per state bit
// - running setting has no dwell field
// - current state reported as 3-bit code
// - re-apply bit re-drives running setting while awake, on the first clock after the write
package wsss_pkg;
	localparam logic [7:0]  WSSS_OFS_CONTROL   = 8'h00;
	localparam logic [7:0]  WSSS_OFS_PHASE_ONE = 8'h10;
	localparam logic [7:0]  WSSS_OFS_PHASE_TWO = 8'h14;
	localparam logic [7:0]  WSSS_OFS_RUNNING   = 8'h18;
	localparam logic [7:0]  WSSS_OFS_STATUS    = 8'h24;
	localparam logic [7:0]  WSSS_OFS_SEQ_CTRL  = 8'h44;
	localparam int          WSSS_BIT_CORE_EN   = 0;
	localparam int          WSSS_BIT_ANA_EN    = 1;
	localparam int          WSSS_BIT_PLL_EN    = 4;
	localparam int          WSSS_BIT_IO_EN     = 5;
	localparam int          WSSS_BIT_CORE_PFM  = 8;
	localparam int          WSSS_BIT_ANA_PFM   = 9;
	localparam int          WSSS_BIT_GATE      = 14;
	localparam int          WSSS_BIT_REAPPLY   = 6;
	localparam int          WSSS_DWELL_LSB     = 16;
	localparam int          WSSS_STATE_LSB     = 16;
	// writable masks: everything else reserved or fixed
	localparam logic [31:0] WSSS_MASK_TIMED    = 32'h001F_4331;
	localparam logic [31:0] WSSS_MASK_RUNNING  = 32'h0000_4331;
	localparam logic [31:0] WSSS_RST_PHASE_ONE = 32'h0010_0020;
	localparam logic [31:0] WSSS_RST_PHASE_TWO = 32'h0010_0033;
	localparam logic [31:0] WSSS_RST_RUNNING   = 32'h0000_0033;
	localparam logic [31:0] WSSS_RST_SEQ_CTRL  = 32'h0000_0000;
	localparam logic [31:0] WSSS_DWELL_MAX     = 32'h8000_0000;
	localparam logic [1:0]  WSSS_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  WSSS_RESP_SLVERR   = 2'h2;
	// gray along reset, asleep, phase one, phase two, awake
	typedef enum logic [2:0] {
		WSSS_ST_RESET  = 3'h0,
		WSSS_ST_ASLEEP = 3'h1,
		WSSS_ST_PHASE1 = 3'h3,
		WSSS_ST_PHASE2 = 3'h2,
		WSSS_ST_AWAKE  = 3'h6
	} wsss_state_t;
	localparam logic [2:0]  WSSS_CODE_RESET    = 3'h0;
	localparam logic [2:0]  WSSS_CODE_ASLEEP   = 3'h1;
	localparam logic [2:0]  WSSS_CODE_PHASE1   = 3'h2;
	localparam logic [2:0]  WSSS_CODE_PHASE2   = 3'h3;
	localparam logic [2:0]  WSSS_CODE_AWAKE    = 3'h5;
endpackage

// ===== wsss_top.sv
// wake sequence supply states: power-up phases and running-state supply drive
// assumes regulators return power-good levels synchronous to CLK
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module wsss_top
	import wsss_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	input  wire logic        WAKE_REQ,
	input  wire logic        SLEEP_REQ,
	input  wire logic        CORE_GOOD,
	input  wire logic        ANA_GOOD,
	input  wire logic        PLL_GOOD,
	input  wire logic        IO_GOOD,
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	output logic             CORE_EN,
	output logic             ANA_EN,
	output logic             PLL_EN,
	output logic             IO_EN,
	output logic             CORE_PFM,
	output logic             ANA_PFM,
	output logic             TILE_CLK_STOP,
	output logic [2:0]       SEQ_STATE
);

////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		merge = (r & mask) | (old & ~mask);
	endfunction

	function automatic logic [2:0] code_of(input wsss_state_t s);
		case (s)
			WSSS_ST_RESET:  code_of = WSSS_CODE_RESET;
			WSSS_ST_ASLEEP: code_of = WSSS_CODE_ASLEEP;
			WSSS_ST_PHASE1: code_of = WSSS_CODE_PHASE1;
			WSSS_ST_PHASE2: code_of = WSSS_CODE_PHASE2;
			WSSS_ST_AWAKE:  code_of = WSSS_CODE_AWAKE;
			default:        code_of = WSSS_CODE_RESET;
		endcase
	endfunction

	// all enabled supplies report good; analogue regulator counted when its bit is set
	function automatic logic all_good(input logic [31:0] s, input logic c, input logic a,
		input logic p, input logic o);
		all_good = (!s[WSSS_BIT_CORE_EN] || c) && (!s[WSSS_BIT_ANA_EN] || a)
			&& (!s[WSSS_BIT_PLL_EN] || p) && (!s[WSSS_BIT_IO_EN] || o);
	endfunction

////////////////////////////////////////////////////////////////////////////////
	logic [31:0] phase_one, phase_two, running, next_phase_one, next_phase_two, next_running;
	logic        aw_held, w_held, next_aw_held, next_w_held;
	logic [7:0]  aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0]  w_strb, next_w_strb;
	logic        next_bvalid, next_rvalid, next_awready, next_wready, next_arready;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic        reapply, next_reapply;
	logic        do_write;

	assign do_write = aw_held && w_held && !BVALID;

	always_comb begin
		next_aw_held   = aw_held;
		next_w_held    = w_held;
		next_aw_addr   = aw_addr;
		next_w_data    = w_data;
		next_w_strb    = w_strb;
		next_awready   = 1'b0;
		next_wready    = 1'b0;
		next_arready   = 1'b0;
		next_bvalid    = BVALID;
		next_bresp     = BRESP;
		next_rvalid    = RVALID;
		next_rresp     = RRESP;
		next_rdata     = RDATA;
		next_phase_one = phase_one;
		next_phase_two = phase_two;
		next_running   = running;
		next_reapply   = 1'b0;
		if (AWVALID && AWREADY) begin
			next_aw_held = 1'b1;
			next_aw_addr = AWADDR;
		end
		if (WVALID && WREADY) begin
			next_w_held = 1'b1;
			next_w_data = WDATA;
			next_w_strb = WSTRB;
		end
		next_awready = !next_aw_held && !AWREADY && !BVALID;
		next_wready  = !next_w_held && !WREADY && !BVALID;
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = WSSS_RESP_OKAY;
			case (aw_addr)
				WSSS_OFS_PHASE_ONE: next_phase_one = merge(phase_one, w_data, w_strb,
					WSSS_MASK_TIMED);
				WSSS_OFS_PHASE_TWO: next_phase_two = merge(phase_two, w_data, w_strb,
					WSSS_MASK_TIMED);
				WSSS_OFS_RUNNING:   next_running = merge(running, w_data, w_strb,
					WSSS_MASK_RUNNING);
				WSSS_OFS_CONTROL:   next_reapply = w_strb[0] && w_data[WSSS_BIT_REAPPLY];
				default:            next_bresp = WSSS_RESP_SLVERR;
			endcase
		end
		if (BVALID && BREADY) begin
			next_bvalid = 1'b0;
		end
		next_arready = ARVALID && !ARREADY && !RVALID;
		if (ARVALID && ARREADY) begin
			next_rvalid = 1'b1;
			next_rresp  = WSSS_RESP_OKAY;
			case (ARADDR)
				WSSS_OFS_PHASE_ONE: next_rdata = phase_one;
				WSSS_OFS_PHASE_TWO: next_rdata = phase_two;
				WSSS_OFS_RUNNING:   next_rdata = running;
				WSSS_OFS_CONTROL:   next_rdata = 32'h0000_0000;
				WSSS_OFS_STATUS:    next_rdata = {13'h0000, SEQ_STATE, 16'h0000};
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = WSSS_RESP_SLVERR;
				end
			endcase
		end else if (RVALID && RREADY) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr   <= 8'h00;
			w_data    <= 32'h0000_0000;
			w_strb    <= 4'h0;
			AWREADY   <= 1'b0;
			WREADY    <= 1'b0;
			ARREADY   <= 1'b0;
			BVALID    <= 1'b0;
			BRESP     <= 2'h0;
			RVALID    <= 1'b0;
			RRESP     <= 2'h0;
			RDATA     <= 32'h0000_0000;
			phase_one <= WSSS_RST_PHASE_ONE;
			phase_two <= WSSS_RST_PHASE_TWO;
			running   <= WSSS_RST_RUNNING;
			reapply   <= 1'b0;
		end else begin
			aw_held   <= next_aw_held;
			w_held    <= next_w_held;
			aw_addr   <= next_aw_addr;
			w_data    <= next_w_data;
			w_strb    <= next_w_strb;
			AWREADY   <= next_awready;
			WREADY    <= next_wready;
			ARREADY   <= next_arready;
			BVALID    <= next_bvalid;
			BRESP     <= next_bresp;
			RVALID    <= next_rvalid;
			RRESP     <= next_rresp;
			RDATA     <= next_rdata;
			phase_one <= next_phase_one;
			phase_two <= next_phase_two;
			running   <= next_running;
			reapply   <= next_reapply;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	wsss_state_t state, next_state;
	logic [31:0] dwell, next_dwell;
	logic [31:0] drive, next_drive;
	logic [31:0] sel;
	logic        dwell_done;

	assign dwell_done = (dwell == 32'h0000_0000);

	always_comb begin
		next_state = state;
		next_dwell = (dwell_done) ? dwell : dwell - 32'h0000_0001;
		sel        = drive;
		case (state)
			WSSS_ST_RESET: begin
				next_state = WSSS_ST_ASLEEP;
			end
			WSSS_ST_ASLEEP: begin
				if (WAKE_REQ) begin
					next_state = WSSS_ST_PHASE1;
					next_dwell = WSSS_DWELL_MAX >> (5'h1F - phase_one[WSSS_DWELL_LSB +: 5]);
					next_dwell = next_dwell - 32'h0000_0001;
					sel        = phase_one;
				end
			end
			WSSS_ST_PHASE1: begin
				if (dwell_done && all_good(phase_one, CORE_GOOD, ANA_GOOD, PLL_GOOD, IO_GOOD)) begin
					next_state = WSSS_ST_PHASE2;
					next_dwell = (WSSS_DWELL_MAX >> (5'h1F - phase_two[WSSS_DWELL_LSB +: 5]))
						- 32'h0000_0001;
					sel        = phase_two;
				end else begin
					sel = phase_one;
				end
			end
			WSSS_ST_PHASE2: begin
				if (dwell_done && all_good(phase_two, CORE_GOOD, ANA_GOOD, PLL_GOOD, IO_GOOD)) begin
					next_state = WSSS_ST_AWAKE;
					sel        = running;
				end else begin
					sel = phase_two;
				end
			end
			WSSS_ST_AWAKE: begin
				// running lasts until sleep; re-apply refreshes drive
				if (reapply) begin
					sel = running;
				end
				if (SLEEP_REQ) begin
					next_state = WSSS_ST_ASLEEP;
					sel        = 32'h0000_0000;
				end
			end
			default: begin
				next_state = WSSS_ST_RESET;
				sel        = 32'h0000_0000;
			end
		endcase
		next_drive = sel;
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= WSSS_ST_RESET;
			dwell <= 32'h0000_0000;
			drive <= 32'h0000_0000;
		end else begin
			state <= next_state;
			dwell <= next_dwell;
			drive <= next_drive;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CORE_EN       <= 1'b0;
			ANA_EN        <= 1'b0;
			PLL_EN        <= 1'b0;
			IO_EN         <= 1'b0;
			CORE_PFM      <= 1'b0;
			ANA_PFM       <= 1'b0;
			TILE_CLK_STOP <= 1'b0;
			SEQ_STATE     <= WSSS_CODE_RESET;
		end else begin
			CORE_EN       <= next_drive[WSSS_BIT_CORE_EN];
			ANA_EN        <= next_drive[WSSS_BIT_ANA_EN];
			PLL_EN        <= next_drive[WSSS_BIT_PLL_EN];
			IO_EN         <= next_drive[WSSS_BIT_IO_EN];
			CORE_PFM      <= next_drive[WSSS_BIT_CORE_PFM];
			ANA_PFM       <= next_drive[WSSS_BIT_ANA_PFM];
			TILE_CLK_STOP <= next_drive[WSSS_BIT_GATE];
			SEQ_STATE     <= code_of(next_state);
		end
	end

////////////////////////////////////////////////////////////////////////////////
	stay_one_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state == WSSS_ST_PHASE1 && !dwell_done) |=> state == WSSS_ST_PHASE1)
		else $error("phase one left before dwell expired");
	good_one_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state == WSSS_ST_PHASE1 && !all_good(phase_one, CORE_GOOD, ANA_GOOD, PLL_GOOD, IO_GOOD))
		|=> state == WSSS_ST_PHASE1)
		else $error("phase one advanced without power good");
	stay_two_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state == WSSS_ST_PHASE2 && !dwell_done) |=> state == WSSS_ST_PHASE2)
		else $error("phase two left before dwell expired");
	dwell_zero_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state == WSSS_ST_ASLEEP && WAKE_REQ && phase_one[20:16] == 5'h00) |=> dwell_done)
		else $error("dwell of one cycle not loaded");
	gate_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state == WSSS_ST_PHASE2) |-> TILE_CLK_STOP == phase_two[WSSS_BIT_GATE])
		else $error("tile clock gate mismatch");
	io_en_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state == WSSS_ST_PHASE1) |-> IO_EN == phase_one[WSSS_BIT_IO_EN])
		else $error("io supply enable mismatch");
	ro_ana_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		##1 ($stable(phase_one[1]) && $stable(running[1])))
		else $error("analogue enable bit changed");
	resv_zero_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		(running & ~WSSS_MASK_RUNNING) == (WSSS_RST_RUNNING & ~WSSS_MASK_RUNNING))
		else $error("reserved running bits changed");
	code_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		SEQ_STATE == code_of(state))
		else $error("state code mismatch");
	wake_c: cover property (@(posedge CLK) disable iff (!ARST_N)
		state == WSSS_ST_PHASE2 ##1 state == WSSS_ST_AWAKE);
	reapply_c: cover property (@(posedge CLK) disable iff (!ARST_N)
		state == WSSS_ST_AWAKE && reapply);
	sleep_c: cover property (@(posedge CLK) disable iff (!ARST_N)
		state == WSSS_ST_AWAKE ##1 state == WSSS_ST_ASLEEP);
endmodule

// ===== wsss_supply_model.sv
// regulator stand-in: four supplies that report good some cycles after enable
// assumes enables come registered from the sequencer on the same clock
`timescale 1ns/1ps
module wsss_supply_model (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [3:0] en,
	input  wire logic [7:0] lag,
	output logic      [3:0] good
);
	int cnt [4];
	////////////////////////////////////////////////////////////////////////
	// good drops on the first clock after a supply is switched off, with no lag count
	always @(posedge clk or negedge arst_n) begin
		for (int i = 0; i < 4; i++) begin
			if (!arst_n || !en[i]) begin
				cnt[i] <= 0;
				good[i] <= 1'b0;
			end else begin
				if (cnt[i] < lag)
					cnt[i] <= cnt[i] + 1;
				good[i] <= (cnt[i] >= lag);
			end
		end
	end
endmodule

// ===== test_wake_sequence_supply_states.sv
// bench: register model and wake walk compared with the sequencer at every result
// assumes wsss_top and wsss_supply_model, one 40 MHz clock
`timescale 1ns/1ps
module test_wake_sequence_supply_states;
	import wsss_pkg::*;
	`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
		$display("wrong value %s expected %h seen %h", nm, e, g); end end
	logic        clk = 0, arst_n = 0, wake = 0, sleep = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = 0, araddr = 0, lag = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0]  wstrb = 0, good;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        core_en, ana_en, pll_en, io_en, core_pfm, ana_pfm, clk_stop;
	logic [1:0]  bresp, rresp, r;
	logic [2:0]  state;
	logic [6:0]  seen;
	logic [31:0] mreg [3] = '{WSSS_RST_PHASE_ONE, WSSS_RST_PHASE_TWO, WSSS_RST_RUNNING};
	int          mismatches = 0, n_checks = 0, cycles = 0;
	assign seen = {clk_stop, ana_pfm, core_pfm, io_en, pll_en, ana_en, core_en};
	////////////////////////////////////////////////////////////////////////
	wsss_top dut (.CLK(clk), .ARST_N(arst_n), .WAKE_REQ(wake), .SLEEP_REQ(sleep),
		.CORE_GOOD(good[0]), .ANA_GOOD(good[1]), .PLL_GOOD(good[2]), .IO_GOOD(good[3]),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
		.WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
		.RREADY(rready), .CORE_EN(core_en), .ANA_EN(ana_en), .PLL_EN(pll_en),
		.IO_EN(io_en), .CORE_PFM(core_pfm), .ANA_PFM(ana_pfm),
		.TILE_CLK_STOP(clk_stop), .SEQ_STATE(state));
	wsss_supply_model regs (.clk(clk), .arst_n(arst_n),
		.en({io_en, pll_en, ana_en, core_en}), .lag(lag), .good(good));
	always #12.5 clk = ~clk;
	// ceiling well above the three wake walks, which need a few hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (mismatches == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	function automatic logic [6:0] drv(input logic [31:0] v);
		return {v[14], v[9], v[8], v[5], v[4], v[1], v[0]};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw, w;
		aw = 0;
		w = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && awready === 1'b1) begin
				aw = 1;
				awvalid <= 0;
			end
			if (!w && wready === 1'b1) begin
				w = 1;
				wvalid <= 0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge clk);
		r = bresp;
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge clk); while (rvalid !== 1'b1);
		r = rresp;
		rready <= 0;
	endtask
	// write a setting, fold it into the model through the writable mask, read back
	task automatic put(input int i, input logic [31:0] d);
		wr(8'h10 + 8'(4 * i), d);
		`CHK("write resp", WSSS_RESP_OKAY, r)
		mreg[i] = (mreg[i] & ~((i < 2) ? WSSS_MASK_TIMED : WSSS_MASK_RUNNING))
			| (d & ((i < 2) ? WSSS_MASK_TIMED : WSSS_MASK_RUNNING));
		rd(8'h10 + 8'(4 * i));
		`CHK("setting", mreg[i], rdata)
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic run(input int lv, input int n1, input int n2);
		int c, lo;
		lag <= 8'(lv);
		put(0, ($urandom & ~32'h001F_0000) | (32'(n1) << 16));
		put(1, ($urandom & ~32'h001F_0000) | (32'(n2) << 16));
		put(2, $urandom);
		@(posedge clk);
		wake <= 1;
		do @(posedge clk); while (state !== WSSS_CODE_PHASE1);
		wake <= 0;
		for (int p = 0; p < 2; p++) begin
			c = 0;
			lo = 1 << (p ? n2 : n1);
			while (state === 3'(p + 2)) begin
				`CHK("phase drive", drv(mreg[p]), seen)
				c++;
				@(posedge clk);
			end
			`CHK("dwell", 1'b1, c >= lo)
			if ((mreg[p] & 32'h33) != 0)
				`CHK("good wait", 1'b1, c >= lv)
			`CHK("advance", 1'b1, c <= lo + lv + 4)
		end
		`CHK("state", WSSS_CODE_AWAKE, state)
		`CHK("run drive", drv(mreg[2]), seen)
		rd(WSSS_OFS_STATUS);
		`CHK("status", 32'(WSSS_CODE_AWAKE) << WSSS_STATE_LSB, rdata)
		// flip every writable bit so the re-apply check below can always trip
		put(2, ~mreg[2]);
		`CHK("held drive", drv(mreg[2] ^ WSSS_MASK_RUNNING), seen)
		wr(WSSS_OFS_CONTROL, 32'h0000_0040);
		repeat (2) @(posedge clk);
		`CHK("reapply", drv(mreg[2]), seen)
		sleep <= 1;
		do @(posedge clk); while (state !== WSSS_CODE_ASLEEP);
		sleep <= 0;
		`CHK("asleep drive", 7'h00, seen)
	endtask
	initial begin
		void'($urandom(93080));
		repeat (6) @(posedge clk);
		arst_n <= 1;
		repeat (2) @(posedge clk);
		`CHK("state", WSSS_CODE_ASLEEP, state)
		for (int i = 0; i < 3; i++) begin
			rd(8'h10 + 8'(4 * i));
			`CHK("reset value", mreg[i], rdata)
		end
		rd(WSSS_OFS_CONTROL);
		`CHK("control", 32'h0000_0000, rdata)
		rd(8'h3C);
		`CHK("unmapped read", WSSS_RESP_SLVERR, r)
		`CHK("unmapped data", 32'h0000_0000, rdata)
		wr(8'h3C, 32'hFFFF_FFFF);
		`CHK("unmapped write", WSSS_RESP_SLVERR, r)
		run(0, 0, 0);
		run(20, 2, 3);
		run(3, 5, 1);
		stop_test();
	end
endmodule
